// file: hgcr_pkg.sv
// Function
// - address field always shows answering address
// - select clear: field read-only, strapped address
// - select set: field writable, programmed address used
// - reset register written only from primary port
// - bit 2 starts ROM reload, self-clears
// - bit 1 resets logic and registers
// - bit 0 resets logic, keeps registers
// - mode 0 with sleep select 1: unlocked output forced high-impedance
// - mode 1 with sleep select 1: per-port control, LP-11 unlocked
// - sleep select 1, enable 0: high-impedance
// - unlocked with sleep select 0: HS-0
// - bit 1 enables receive parity checking
// - bit 0 forces reference-present indication
// - configuration register resets to 0x1E
// - init-done status bit 6 after load
package hgcr_pkg;
  localparam logic [7:0] ADDR_BUS_TARGET  = 8'h00;
  localparam logic [7:0] ADDR_RESET_CMD   = 8'h01;
  localparam logic [7:0] ADDR_GEN_CFG     = 8'h02;
  localparam logic [7:0] RST_BUS_TARGET   = 8'h00;
  localparam logic [7:0] RST_RESET_CMD    = 8'h00;
  localparam logic [7:0] RST_GEN_CFG      = 8'h1E;
  localparam int         BIT_ADDR_SEL     = 0;
  localparam int         BIT_ROM_RELOAD   = 2;
  localparam int         BIT_FULL_RST     = 1;
  localparam int         BIT_KEEP_RST     = 0;
  localparam int         BIT_OE_MODE      = 4;
  localparam int         BIT_OUT_EN       = 3;
  localparam int         BIT_SLEEP_SEL    = 2;
  localparam int         BIT_PARITY_EN    = 1;
  localparam int         BIT_FORCE_REF    = 0;
  localparam int         BIT_INIT_DONE    = 6;
  localparam logic [7:0] GEN_CFG_MASK     = 8'h1F;
  localparam logic [3:0] LOGIC_RST_CYCLES = 4'h4;

  // output state per camera-serial port
  typedef enum logic [1:0] {
    HGCR_OUT_NORMAL = 2'b00,
    HGCR_OUT_HIZ    = 2'b01,
    HGCR_OUT_LP11   = 2'b10,
    HGCR_OUT_HS0    = 2'b11
  } hgcr_out_state_t;

  // register write request
  typedef struct packed {
    logic       wr;
    logic       primary;
    logic [7:0] addr;
    logic [7:0] data;
  } hgcr_wr_req_t;
endpackage

// file: hgcr_out_ctl.sv
`timescale 1ns/10ps
`default_nettype none
// decides one camera-serial port's output state from lock and configuration
module hgcr_out_ctl (
  input  wire logic                     clk_sys_i,    // system clock
  input  wire logic                     reset_i,      // sync reset
  input  wire logic                     locked_i,     // any assigned receiver locked
  input  wire logic [7:0]               cfg_i,        // configuration register
  output hgcr_pkg::hgcr_out_state_t     state_o       // registered output state
);
  hgcr_pkg::hgcr_out_state_t state_nxt;

  // sleep/enable combination wins over lock handling since it forces the pins
  always_comb begin
    state_nxt = hgcr_pkg::HGCR_OUT_NORMAL;
    if (cfg_i[hgcr_pkg::BIT_SLEEP_SEL] && !cfg_i[hgcr_pkg::BIT_OUT_EN]) begin
      state_nxt = hgcr_pkg::HGCR_OUT_HIZ;
    end else if (!locked_i) begin
      if (!cfg_i[hgcr_pkg::BIT_SLEEP_SEL]) begin
        state_nxt = hgcr_pkg::HGCR_OUT_HS0;
      end else if (!cfg_i[hgcr_pkg::BIT_OE_MODE]) begin
        state_nxt = hgcr_pkg::HGCR_OUT_HIZ;
      end else begin
        state_nxt = hgcr_pkg::HGCR_OUT_LP11;
      end
    end
  end

  // registered so the pin state never glitches
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_o <= hgcr_pkg::HGCR_OUT_HIZ;
    end else begin
      state_o <= state_nxt;
    end
  end
endmodule
`default_nettype wire

// file: hub_global_control_regs.sv
`timescale 1ns/10ps
`default_nettype none
// global control registers: own address, reset commands, general configuration
module hub_global_control_regs #(
  parameter int NUM_OUT = 2                                   // camera-serial output ports
) (
  input  wire logic                              clk_sys_i,     // system clock
  input  wire logic                              reset_i,       // sync reset, high
  input  wire logic [6:0]                        strap_addr_i,  // strap pins
  input  wire hgcr_pkg::hgcr_wr_req_t            wr_req_i,      // register write
  input  wire logic [7:0]                        rd_addr_i,     // register read address
  output logic [7:0]                             rd_data_o,     // registered read data
  input  wire logic                              rom_done_i,    // ROM load finished, pulse
  output logic                                   rom_start_o,   // ROM load start, pulse
  input  wire logic [NUM_OUT-1:0]                locked_i,      // lock per output port
  input  wire logic                              ref_detect_i,  // reference clock detector
  output logic                                   ref_present_o, // reference present indication
  output logic                                   parity_en_o,   // receive parity checking
  output logic [6:0]                             own_addr_o,    // address answered to
  output logic [7:0]                             device_status_reg_o, // status byte
  output logic                                   logic_rst_o,   // logic reset, regs kept
  output hgcr_pkg::hgcr_out_state_t [NUM_OUT-1:0] out_state_o   // output state per port
);
  logic [6:0] strap_s1_r;
  logic [6:0] strap_s2_r;
  logic [6:0] strap_latch_r;
  logic       strap_taken_r;
  logic [6:0] prog_addr_r;
  logic       address_source_select_r;
  logic [7:0] gen_cfg_r;
  logic       rom_busy_r;
  logic       init_done_r;
  logic [3:0] rst_cnt_r;
  logic       full_rst_r;
  logic       regs_rst;
  logic       wr_fire;
  logic       rst_wr;
  logic [7:0] rst_cmd;

  // register reset combines pin reset and the full-logic command
  assign regs_rst = reset_i | full_rst_r;
  assign wr_fire  = wr_req_i.wr;
  assign rst_wr   = wr_fire && wr_req_i.primary && wr_req_i.addr == hgcr_pkg::ADDR_RESET_CMD;

  // strap pins are asynchronous, so two stages first
  always_ff @(posedge clk_sys_i) begin
    strap_s1_r <= strap_addr_i;
    strap_s2_r <= strap_s1_r;
  end

  // strap captured once after reset release, from the synchronised copy
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      strap_taken_r <= 1'b0;
      strap_latch_r <= 7'h00;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      strap_latch_r <= strap_s2_r;
    end
  end

  // address register
  always_ff @(posedge clk_sys_i) begin
    if (regs_rst) begin
      prog_addr_r             <= hgcr_pkg::RST_BUS_TARGET[7:1];
      address_source_select_r <= hgcr_pkg::RST_BUS_TARGET[hgcr_pkg::BIT_ADDR_SEL];
    end else if (wr_fire && wr_req_i.addr == hgcr_pkg::ADDR_BUS_TARGET) begin
      address_source_select_r <= wr_req_i.data[hgcr_pkg::BIT_ADDR_SEL];
      // field writable only while override is selected
      if (address_source_select_r) begin
        prog_addr_r <= wr_req_i.data[7:1];
      end
    end
  end

  // answering address: strap unless override selected
  assign own_addr_o = address_source_select_r ? prog_addr_r : strap_latch_r;

  // general configuration; reserved bits never stored
  always_ff @(posedge clk_sys_i) begin
    if (regs_rst) begin
      gen_cfg_r <= hgcr_pkg::RST_GEN_CFG;
    end else if (wr_fire && wr_req_i.addr == hgcr_pkg::ADDR_GEN_CFG) begin
      gen_cfg_r <= wr_req_i.data & hgcr_pkg::GEN_CFG_MASK;
    end
  end

  assign parity_en_o   = gen_cfg_r[hgcr_pkg::BIT_PARITY_EN];
  assign ref_present_o = gen_cfg_r[hgcr_pkg::BIT_FORCE_REF] | ref_detect_i;

  // full reset: one cycle pulse that clears registers; itself reset only by pin
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      full_rst_r <= 1'b0;
    end else begin
      full_rst_r <= rst_wr && wr_req_i.data[hgcr_pkg::BIT_FULL_RST];
    end
  end

  // logic reset without registers: stretched a few cycles, ones only act
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rst_cnt_r <= 4'h0;
    end else if (rst_wr && (wr_req_i.data[hgcr_pkg::BIT_KEEP_RST] || wr_req_i.data[hgcr_pkg::BIT_FULL_RST])) begin
      rst_cnt_r <= hgcr_pkg::LOGIC_RST_CYCLES;
    end else if (rst_cnt_r != 4'h0) begin
      rst_cnt_r <= rst_cnt_r - 4'h1;
    end
  end
  assign logic_rst_o = (rst_cnt_r != 4'h0);

  // ROM reload: busy until done; init-done drops while loading
  always_ff @(posedge clk_sys_i) begin
    if (regs_rst) begin
      rom_busy_r  <= 1'b0;
      rom_start_o <= 1'b0;
    end else begin
      rom_start_o <= 1'b0;
      if (rst_wr && wr_req_i.data[hgcr_pkg::BIT_ROM_RELOAD] && !rom_busy_r) begin
        rom_busy_r  <= 1'b1;
        rom_start_o <= 1'b1;
      end else if (rom_done_i) begin
        rom_busy_r  <= 1'b0;
      end
    end
  end

  // init-done assumes power-up load already completed when reset ends
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      init_done_r <= 1'b1;
    end else if (rom_done_i) begin
      init_done_r <= 1'b1;
    end else if (rom_start_o) begin
      init_done_r <= 1'b0;
    end
  end

  assign device_status_reg_o = {1'b0, init_done_r, 6'h00};

  // self-clearing bits read back as live activity; reserved read zero
  always_comb begin
    rst_cmd = 8'h00;
    rst_cmd[hgcr_pkg::BIT_ROM_RELOAD] = rom_busy_r;
    rst_cmd[hgcr_pkg::BIT_FULL_RST]   = full_rst_r;
    rst_cmd[hgcr_pkg::BIT_KEEP_RST]   = logic_rst_o;
  end

  // registered read mux; unmapped offsets read zero
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rd_data_o <= 8'h00;
    end else begin
      case (rd_addr_i)
        hgcr_pkg::ADDR_BUS_TARGET: rd_data_o <= {own_addr_o, address_source_select_r};
        hgcr_pkg::ADDR_RESET_CMD:  rd_data_o <= rst_cmd;
        hgcr_pkg::ADDR_GEN_CFG:    rd_data_o <= gen_cfg_r;
        default:                   rd_data_o <= 8'h00;
      endcase
    end
  end

  // one output controller per port
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    hgcr_out_ctl u_out (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i | logic_rst_o),
      .locked_i  (locked_i[g]),
      .cfg_i     (gen_cfg_r),
      .state_o   (out_state_o[g])
    );
  end
endmodule
`default_nettype wire

// file: hgcr_checker.sv
`timescale 1ns/10ps
`default_nettype none
// timing relations seen at the ports; checks that need the configuration byte live in the bench
module hgcr_checker (
  input wire logic                   clk_sys_i,           // clock
  input wire logic                   reset_i,             // sync reset
  input wire logic [6:0]             strap_addr_i,        // straps
  input wire hgcr_pkg::hgcr_wr_req_t wr_req_i,            // write
  input wire logic [7:0]             rd_addr_i,           // read address
  input wire logic [7:0]             rd_data_o,           // read data
  input wire logic                   rom_done_i,          // load done
  input wire logic                   rom_start_o,         // load start
  input wire logic                   ref_detect_i,        // detector
  input wire logic                   ref_present_o,       // indication
  input wire logic [6:0]             own_addr_o,          // answered address
  input wire logic [7:0]             device_status_reg_o, // status
  input wire logic                   logic_rst_o          // logic reset
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  logic rst_wr;
  logic rd0_ok;
  logic rst_q;
  // first edge after release still reads pre-strap state, so quiet reads skip it
  always_ff @(posedge clk_sys_i) begin
    rst_q <= reset_i;
  end
  // decoded primary write to the command register, and a quiet read of the address byte
  assign rst_wr = wr_req_i.wr && wr_req_i.primary && wr_req_i.addr == hgcr_pkg::ADDR_RESET_CMD;
  assign rd0_ok = rd_addr_i == 8'h00 && !wr_req_i.wr && !logic_rst_o && !reset_i && !rst_q;
  property p_reload; rst_wr && wr_req_i.data[2:0] == 3'h4 && device_status_reg_o[6] |=> rom_start_o; endproperty
  a_reload: assert property (p_reload) else $error("reload start missing");
  property p_foreign; wr_req_i.wr && !wr_req_i.primary && wr_req_i.addr == 8'h01 |=> !rom_start_o && !$rose(logic_rst_o); endproperty
  a_foreign: assert property (p_foreign) else $error("remote command obeyed");
  property p_busy; rom_start_o |=> !device_status_reg_o[6]; endproperty
  a_busy: assert property (p_busy) else $error("init done stayed during load");
  property p_done; rom_done_i && !device_status_reg_o[6] |=> device_status_reg_o[6]; endproperty
  a_done: assert property (p_done) else $error("init done not set");
  property p_lrst; rst_wr && wr_req_i.data[1:0] != 2'h0 |=> logic_rst_o [*4] ##1 !logic_rst_o; endproperty
  a_lrst: assert property (p_lrst) else $error("logic reset length wrong");
  property p_ref; ref_detect_i |-> ref_present_o; endproperty
  a_ref: assert property (p_ref) else $error("detected reference not shown");
  property p_addr; rd0_ok |=> rd_data_o[7:1] == $past(own_addr_o); endproperty
  a_addr: assert property (p_addr) else $error("address field differs from answered address");
  property p_strap; $past(rd0_ok) && !rd_data_o[0] |-> rd_data_o[7:1] == strap_addr_i; endproperty
  a_strap: assert property (p_strap) else $error("strapped address not shown");
  property p_unmap; rd_addr_i > 8'h04 |=> rd_data_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_resv; rd_addr_i == 8'h01 |=> rd_data_o[7:3] == 5'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved command bits set");
endmodule
bind hub_global_control_regs hgcr_checker u_chk (.clk_sys_i, .reset_i, .strap_addr_i, .wr_req_i, .rd_addr_i,
  .rd_data_o, .rom_done_i, .rom_start_o, .ref_detect_i, .ref_present_o, .own_addr_o, .device_status_reg_o,
  .logic_rst_o);
`default_nettype wire

// file: hgcr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// local-port host: single-byte accesses, clear primary stands for remote link traffic
module hgcr_host_model (
  input  wire logic              clk_sys_i, // clock
  input  wire logic [7:0]        rd_data_i, // read data
  input  wire logic [7:0]        status_i,  // status byte
  output hgcr_pkg::hgcr_wr_req_t wr_req_o,  // write request
  output logic [7:0]             rd_addr_o  // read address
);
  // idle bus from time zero
  initial begin
    wr_req_o = 18'h00000;
    rd_addr_o = 8'h00;
  end
  // one-cycle strobe, fields held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic p);
    @(posedge clk_sys_i);
    wr_req_o <= '{wr: 1'b1, primary: p, addr: a, data: d};
    @(posedge clk_sys_i);
    wr_req_o.wr <= 1'b0;
  endtask
  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    rd_addr_o <= a;
    @(posedge clk_sys_i);
    #1 d = rd_data_i;
  endtask
  // reloaded setup is trusted only once init-done is back, bounded wait
  task automatic poll(output logic ok);
    ok = 1'b0;
    for (int k = 0; k < 64 && !ok; k++) begin
      @(posedge clk_sys_i);
      #1 ok = status_i[hgcr_pkg::BIT_INIT_DONE];
    end
  endtask
endmodule
`default_nettype wire

// file: hub_global_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module hub_global_control_regs_tb;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [6:0] strap = 7'h00;
  logic [6:0] a;
  logic [6:0] own;
  logic rom_done = 1'b0;
  logic ref_det = 1'b0;
  logic [1:0] locked = 2'h0;
  hgcr_pkg::hgcr_wr_req_t wr_req;
  hgcr_pkg::hgcr_out_state_t [1:0] ostate;
  logic [7:0] rd_addr, rd_data, status, d, c;
  logic rom_start, ref_pres, par_en, lrst, ok;
  int failures = 0;
  int compares = 0;
  int k;
  always #20 clk_sys_i = ~clk_sys_i;
  hub_global_control_regs #(.NUM_OUT(2)) u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .strap_addr_i(strap),
    .wr_req_i(wr_req), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rom_done_i(rom_done), .rom_start_o(rom_start),
    .locked_i(locked), .ref_detect_i(ref_det), .ref_present_o(ref_pres), .parity_en_o(par_en), .own_addr_o(own),
    .device_status_reg_o(status), .logic_rst_o(lrst), .out_state_o(ostate));
  hgcr_host_model u_host (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data), .status_i(status), .wr_req_o(wr_req),
    .rd_addr_o(rd_addr));
  // enable/sleep override first, then lock, then the unlocked idle choice
  function automatic hgcr_pkg::hgcr_out_state_t exp_state(logic [7:0] cf, logic l);
    return (cf[2] && !cf[3]) ? hgcr_pkg::HGCR_OUT_HIZ : l ? hgcr_pkg::HGCR_OUT_NORMAL :
      !cf[2] ? hgcr_pkg::HGCR_OUT_HS0 : !cf[4] ? hgcr_pkg::HGCR_OUT_HIZ : hgcr_pkg::HGCR_OUT_LP11;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
    u_host.rd(ad, d);
    chk(d, exp);
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence: straps, address select, commands, configuration sweep, full reset
  initial begin
    void'($urandom(15187));
    strap <= 7'($urandom());
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rdc(8'h02, 8'h1E);
    chk(8'(par_en), 8'h01);
    a = ~strap;
    u_host.wr(8'h00, {a, 1'b0}, 1'b1);
    rdc(8'h00, {strap, 1'b0});
    u_host.wr(8'h00, {a, 1'b1}, 1'b1);
    u_host.wr(8'h00, {a, 1'b1}, 1'b1);
    rdc(8'h00, {a, 1'b1});
    chk(8'(own), 8'(a));
    u_host.wr(8'h01, 8'h07, 1'b0);
    u_host.wr(8'h01, 8'h00, 1'b1);
    rdc(8'h01, 8'h00);
    rdc(8'h00, {a, 1'b1});
    u_host.wr(8'h01, 8'h04, 1'b1);
    // the start pulse is launched at the taking edge, so let it settle before looking
    #1 k = 0;
    while (rom_start !== 1'b1 && k < 4) begin
      @(posedge clk_sys_i);
      #1 k++;
    end
    chk(8'(rom_start), 8'h01);
    @(posedge clk_sys_i);
    #1 chk(8'(status[6]), 8'h00);
    fork
      begin
        repeat ($urandom_range(9, 2)) @(posedge clk_sys_i);
        rom_done <= 1'b1;
        @(posedge clk_sys_i);
        rom_done <= 1'b0;
      end
      u_host.poll(ok);
    join
    chk(8'(ok), 8'h01);
    rdc(8'h01, 8'h00);
    u_host.wr(8'h01, 8'h01, 1'b1);
    repeat (6) @(posedge clk_sys_i);
    rdc(8'h00, {a, 1'b1});
    // every combination of the five configuration bits, random lock and detector
    for (int i = 0; i < 64; i++) begin
      c = {3'($urandom()), 5'(i)};
      u_host.wr(8'h02, c, 1'b1);
      locked <= 2'($urandom());
      ref_det <= 1'($urandom());
      repeat (3) @(posedge clk_sys_i);
      #1 chk(8'(ostate[0]), 8'(exp_state(c, locked[0])));
      chk(8'(ostate[1]), 8'(exp_state(c, locked[1])));
      chk(8'(par_en), 8'(c[1]));
      chk(8'(ref_pres), 8'(c[0] | ref_det));
      rdc(8'h02, c & 8'h1F);
      rdc(8'($urandom_range(255, 5)), 8'h00);
    end
    u_host.wr(8'h01, 8'h02, 1'b1);
    repeat (6) @(posedge clk_sys_i);
    rdc(8'h00, {strap, 1'b0});
    rdc(8'h02, 8'h1E);
    tally_and_finish();
  end
  // hang guard, well beyond the expected run of about six hundred fifty cycles
  initial begin
    repeat (6000) @(posedge clk_sys_i);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
